// ==== logic/alr_pkg.sv ====
// Constants for the audio link send/return router
package alr_pkg;
   localparam int SMP_W      = 24;
   localparam int N_CH       = 16;
   localparam int N_SEND     = 32;
   localparam int N_RET      = 18;
   localparam int N_PAIR     = 8;
   localparam int N_SRC      = 13;
   localparam int FIFO_DEPTH = 8;
   localparam int SEL_W      = 4;

   localparam logic [3:0]  REG_CH_SRC  = 4'h0;
   localparam logic [3:0]  REG_CH_TAP  = 4'h4;
   localparam logic [3:0]  REG_PAIR    = 4'h8;
   localparam logic [3:0]  REG_STATUS  = 4'hC;

   localparam logic [31:0] PAIR_RESET  = 32'h00000000;
   localparam int          ST_OVR_BIT  = 0;
   localparam int          ST_BUSY_BIT = 1;
   localparam int          ST_CNT_LSB  = 16;

   localparam logic [4:0]  SLOT_LAST   = 5'h1F;
   localparam logic [4:0]  RET_LAST    = 5'h11;
   localparam logic [4:0]  RET_PB_L    = 5'h10;
   localparam logic [4:0]  RET_PB_R    = 5'h11;

   typedef enum logic [3:0] {
      ALR_SRC_MAIN     = 4'h0,
      ALR_SRC_SUB12    = 4'h1,
      ALR_SRC_SUB34    = 4'h2,
      ALR_SRC_AUX12    = 4'h3,
      ALR_SRC_AUX34    = 4'h4,
      ALR_SRC_AUX56    = 4'h5,
      ALR_SRC_FX_SEND  = 4'h6,
      ALR_SRC_AUX_RETB = 4'h7,
      ALR_SRC_FX_RETA  = 4'h8,
      ALR_SRC_FX_RETB  = 4'h9,
      ALR_SRC_PLAYBACK = 4'hA,
      ALR_SRC_TALKBACK = 4'hB,
      ALR_SRC_SOLO     = 4'hC
   } alr_src_e;

   typedef enum logic [0:0] {
      ALR_ST_IDLE = 1'b0,
      ALR_ST_PUSH = 1'b1
   } alr_state_e;
endpackage : alr_pkg

// ==== logic/alr_router.sv ====
// Send FIFO and the audio link send/return router
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module alr_fifo #(
   parameter int W = 24,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] wp_nxt;
   logic [AW-1:0] rp_r;
   logic [AW-1:0] rp_nxt;
   logic [AW:0]   cnt_r;
   logic [AW:0]   cnt_nxt;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wp_nxt  = push ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
      rp_nxt  = pop ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage needs no reset; it is never read while empty
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule : alr_fifo

module alr_router (
   input  wire logic                                       clk,
   input  wire logic                                       rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]                                 avs_address,
   input  wire logic                                       avs_read,
   input  wire logic                                       avs_write,
   input  wire logic [31:0]                                avs_writedata,
   output logic [31:0]                                     avs_readdata,
   output logic                                            avs_waitrequest,
   // Mixer side
   input  wire logic                                       frame_stb,
   input  wire logic [alr_pkg::N_CH-1:0][alr_pkg::SMP_W-1:0]  ch_analog_smp,
   input  wire logic [alr_pkg::N_CH-1:0][alr_pkg::SMP_W-1:0]  ch_pre_smp,
   input  wire logic [alr_pkg::N_CH-1:0][alr_pkg::SMP_W-1:0]  ch_post_smp,
   input  wire logic [alr_pkg::N_SRC-1:0][alr_pkg::SMP_W-1:0] src_l_smp,
   input  wire logic [alr_pkg::N_SRC-1:0][alr_pkg::SMP_W-1:0] src_r_smp,
   input  wire logic [alr_pkg::SMP_W-1:0]                  talkback_smp,
   output logic [alr_pkg::N_CH-1:0][alr_pkg::SMP_W-1:0]    ch_in_smp,
   output logic [alr_pkg::N_CH-1:0]                        ch_tap_led,
   output logic [alr_pkg::N_CH-1:0]                        ch_bus_post,
   output logic [alr_pkg::SMP_W-1:0]                       pb_ret_l,
   output logic [alr_pkg::SMP_W-1:0]                       pb_ret_r,
   output logic [alr_pkg::SMP_W-1:0]                       mon_ret_l,
   output logic [alr_pkg::SMP_W-1:0]                       mon_ret_r,
   // Link side, slot-serial
   output logic [alr_pkg::SMP_W-1:0]                       tx_data,
   output logic                                            tx_valid,
   input  wire logic                                       tx_ready,
   output logic                                            tx_first,
   input  wire logic [alr_pkg::SMP_W-1:0]                  rx_data,
   input  wire logic                                       rx_valid,
   input  wire logic                                       rx_first
);
   localparam int W  = alr_pkg::SMP_W;
   localparam int FW = W + 1;

   // Register state
   logic [alr_pkg::N_CH-1:0]   ch_src_r;
   logic [alr_pkg::N_CH-1:0]   ch_src_nxt;
   logic [alr_pkg::N_CH-1:0]   ch_tap_r;
   logic [alr_pkg::N_CH-1:0]   ch_tap_nxt;
   logic [31:0]                pair_r;
   logic [31:0]                pair_nxt;
   logic                       ovr_r;
   logic                       ovr_nxt;
   logic [15:0]                fcnt_r;
   logic [15:0]                fcnt_nxt;
   logic                       ack_r;
   logic                       ack_nxt;
   logic [31:0]                rdata_r;
   logic [31:0]                rdata_nxt;
   logic                       req;
   logic                       wr_go;

   // Send side state
   logic [W-1:0]               slot_smp [alr_pkg::N_SEND];
   logic [W-1:0]               snap_r   [alr_pkg::N_SEND];
   logic [4:0]                 slot_r;
   logic [4:0]                 slot_nxt;
   alr_pkg::alr_state_e        st_r;
   alr_pkg::alr_state_e        st_nxt;
   logic                       take;
   logic                       f_in_ready;
   logic [FW-1:0]              f_out;

   // Return side state
   logic [W-1:0]               ret_r [alr_pkg::N_RET];
   logic [4:0]                 rslot_r;
   logic [4:0]                 rslot_nxt;
   logic [4:0]                 rwr;

   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign wr_go           = avs_write & ack_r;

   // Registers: one wait cycle, then answer
   always_comb begin
      ack_nxt    = req & ~ack_r;
      ch_src_nxt = ch_src_r;
      ch_tap_nxt = ch_tap_r;
      pair_nxt   = pair_r;
      ovr_nxt    = ovr_r;
      rdata_nxt  = rdata_r;
      if (wr_go) begin
         unique case (avs_address)
            alr_pkg::REG_CH_SRC: ch_src_nxt = avs_writedata[alr_pkg::N_CH-1:0];
            alr_pkg::REG_CH_TAP: ch_tap_nxt = avs_writedata[alr_pkg::N_CH-1:0];
            alr_pkg::REG_PAIR:   pair_nxt   = avs_writedata;
            alr_pkg::REG_STATUS: if (avs_writedata[alr_pkg::ST_OVR_BIT]) ovr_nxt = 1'b0;
            default: ;
         endcase
      end
      // Frame arriving while the previous one is still being pushed into the FIFO is dropped; set beats clear
      if (frame_stb && st_r == alr_pkg::ALR_ST_PUSH) begin
         ovr_nxt = 1'b1;
      end
      if (avs_read && !ack_r) begin
         unique case (avs_address)
            alr_pkg::REG_CH_SRC: rdata_nxt = {16'h0000, ch_src_r};
            alr_pkg::REG_CH_TAP: rdata_nxt = {16'h0000, ch_tap_r};
            alr_pkg::REG_PAIR:   rdata_nxt = pair_r;
            alr_pkg::REG_STATUS: rdata_nxt = {fcnt_r, 14'h0000, st_r == alr_pkg::ALR_ST_PUSH, ovr_r};
            default:             rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r    <= 1'b0;
         ch_src_r <= '0;
         ch_tap_r <= '0;
         pair_r   <= alr_pkg::PAIR_RESET;
         ovr_r    <= 1'b0;
         rdata_r  <= 32'h00000000;
      end else begin
         ack_r    <= ack_nxt;
         ch_src_r <= ch_src_nxt;
         ch_tap_r <= ch_tap_nxt;
         pair_r   <= pair_nxt;
         ovr_r    <= ovr_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Channel taps and input source selection
   genvar c;
   generate
      for (c = 0; c < alr_pkg::N_CH; c++) begin : g_ch
         // Processing is withheld from a return-fed channel even with tap on
         wire post_ok = ch_tap_r[c] & ~ch_src_r[c];
         assign slot_smp[c]    = post_ok ? ch_post_smp[c] : ch_pre_smp[c];
         assign ch_tap_led[c]  = ch_tap_r[c];
         assign ch_bus_post[c] = ~(ch_tap_r[c] & ch_src_r[c]);
         assign ch_in_smp[c]   = ch_src_r[c] ? ret_r[c] : ch_analog_smp[c];
      end
   endgenerate

   // Stereo pairs; bus sources arrive post-fader and ignore tap select
   genvar p;
   generate
      for (p = 0; p < alr_pkg::N_PAIR; p++) begin : g_pair
         wire [alr_pkg::SEL_W-1:0] sel = pair_r[p*alr_pkg::SEL_W +: alr_pkg::SEL_W];
         wire is_tb  = (sel == alr_pkg::ALR_SRC_TALKBACK);
         wire ok     = (sel < alr_pkg::SEL_W'(alr_pkg::N_SRC));
         // Unused select codes send silence rather than a stale source
         assign slot_smp[alr_pkg::N_CH + 2*p] =
            is_tb ? talkback_smp : ok ? src_l_smp[sel] : '0;
         assign slot_smp[alr_pkg::N_CH + 2*p + 1] =
            is_tb ? talkback_smp : ok ? src_r_smp[sel] : '0;
      end
   endgenerate

   // Send serializer: snapshot all 32 slots, push them in order
   assign take = (st_r == alr_pkg::ALR_ST_PUSH) & f_in_ready;

   always_comb begin
      st_nxt   = st_r;
      slot_nxt = slot_r;
      fcnt_nxt = fcnt_r;
      unique case (st_r)
         alr_pkg::ALR_ST_IDLE: begin
            if (frame_stb) begin
               st_nxt   = alr_pkg::ALR_ST_PUSH;
               slot_nxt = '0;
            end
         end
         alr_pkg::ALR_ST_PUSH: begin
            if (take) begin
               slot_nxt = slot_r + 1'b1;
               if (slot_r == alr_pkg::SLOT_LAST) begin
                  st_nxt   = alr_pkg::ALR_ST_IDLE;
                  fcnt_nxt = fcnt_r + 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r   <= alr_pkg::ALR_ST_IDLE;
         slot_r <= '0;
         fcnt_r <= '0;
      end else begin
         st_r   <= st_nxt;
         slot_r <= slot_nxt;
         fcnt_r <= fcnt_nxt;
      end
   end

   genvar s;
   generate
      for (s = 0; s < alr_pkg::N_SEND; s++) begin : g_snap
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               snap_r[s] <= '0;
            end else if (frame_stb && st_r == alr_pkg::ALR_ST_IDLE) begin
               snap_r[s] <= slot_smp[s];
            end
         end
      end
   endgenerate

   alr_fifo #(
      .W (FW),
      .D (alr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   ({slot_r == '0, snap_r[slot_r]}),
      .in_valid  (st_r == alr_pkg::ALR_ST_PUSH),
      .in_ready  (f_in_ready),
      .out_data  (f_out),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );

   assign tx_data  = f_out[W-1:0];
   assign tx_first = f_out[W];

   // Return deserializer: every slot taken, selects do not gate it
   always_comb begin
      rwr       = rx_first ? '0 : rslot_r;
      rslot_nxt = rslot_r;
      if (rx_valid) begin
         rslot_nxt = (rwr == alr_pkg::RET_LAST) ? '0 : rwr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rslot_r <= '0;
      end else begin
         rslot_r <= rslot_nxt;
      end
   end

   genvar r;
   generate
      for (r = 0; r < alr_pkg::N_RET; r++) begin : g_ret
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ret_r[r] <= '0;
            end else if (rx_valid && rwr == 5'(r)) begin
               ret_r[r] <= rx_data;
            end
         end
      end
   endgenerate

   assign pb_ret_l  = ret_r[alr_pkg::RET_PB_L];
   assign pb_ret_r  = ret_r[alr_pkg::RET_PB_R];
   assign mon_ret_l = ret_r[alr_pkg::RET_PB_L];
   assign mon_ret_r = ret_r[alr_pkg::RET_PB_R];
endmodule : alr_router

// ==== verification/alr_host.sv ====
// Host-side partner: drains sends and streams returns
`timescale 1ns/1ps
module alr_host (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [6:0]                stall_pct,
   output logic                           tx_ready,
   output logic [alr_pkg::SMP_W-1:0]      rx_data,
   output logic                           rx_valid,
   output logic                           rx_first
);
   logic [4:0]                 slot_r;
   logic [15:0]                frm_r;
   logic [alr_pkg::SMP_W-1:0]  val;
   assign val = {frm_r, 3'h0, slot_r};
   // Idle cycles show the inverse so stale data never matches
   assign rx_data = rx_valid ? val : ~val;
   assign rx_first = rx_valid && slot_r == 5'h00;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         slot_r <= 5'h00;
         frm_r <= 16'h0000;
      end else begin
         tx_ready <= 7'($urandom_range(99)) >= stall_pct;
         rx_valid <= 7'($urandom_range(99)) >= stall_pct;
         if (rx_valid) begin
            slot_r <= (slot_r == alr_pkg::RET_LAST) ? 5'h00 : slot_r + 5'h01;
            frm_r <= (slot_r == alr_pkg::RET_LAST) ? frm_r + 16'h0001 : frm_r;
         end
      end
   end
endmodule : alr_host

// ==== verification/alr_props.sv ====
// Checker on the router's bus, send stream and return ports
`timescale 1ns/1ps
module alr_props (
   input wire logic                                          clk,
   input wire logic                                          rst_n,
   input wire logic                                          avs_read,
   input wire logic                                          avs_write,
   input wire logic                                          avs_waitrequest,
   input wire logic [alr_pkg::N_CH-1:0][alr_pkg::SMP_W-1:0] ch_analog_smp,
   input wire logic [alr_pkg::N_CH-1:0][alr_pkg::SMP_W-1:0] ch_in_smp,
   input wire logic [alr_pkg::N_CH-1:0]                     ch_tap_led,
   input wire logic [alr_pkg::N_CH-1:0]                     ch_bus_post,
   input wire logic [alr_pkg::SMP_W-1:0]                    pb_ret_l,
   input wire logic [alr_pkg::SMP_W-1:0]                    pb_ret_r,
   input wire logic [alr_pkg::SMP_W-1:0]                    mon_ret_l,
   input wire logic [alr_pkg::SMP_W-1:0]                    tx_data,
   input wire logic                                          tx_valid,
   input wire logic                                          tx_ready,
   input wire logic                                          tx_first,
   input wire logic [alr_pkg::SMP_W-1:0]                    rx_data,
   input wire logic                                          rx_valid,
   input wire logic                                          rx_first
);
   logic [4:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt, rx_cur;
   // tx_cnt_r wraps at 32 in five bits, one full send frame; rx_cnt_r wraps after RET_LAST
   always_comb begin
      rx_cur = rx_first ? 5'h00 : rx_cnt_r;
      tx_cnt_nxt = (tx_valid && tx_ready) ? tx_cnt_r + 5'h01 : tx_cnt_r;
      rx_cnt_nxt = rx_cnt_r;
      if (rx_valid)
         rx_cnt_nxt = (rx_cur == alr_pkg::RET_LAST) ? 5'h00 : rx_cur + 5'h01;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt_r <= 5'h00;
         rx_cnt_r <= 5'h00;
      end else begin
         tx_cnt_r <= tx_cnt_nxt;
         rx_cnt_r <= rx_cnt_nxt;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rx_pb; rx_valid && rx_cur == alr_pkg::RET_PB_L; endsequence
   sequence s_stall; tx_valid && !tx_ready; endsequence
   property p_pb; s_rx_pb |=> pb_ret_l == $past(rx_data) && mon_ret_l == $past(rx_data); endproperty
   property p_hold; s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_first); endproperty
   property p_first; tx_valid |-> tx_first == (tx_cnt_r == 5'h00); endproperty
   property p_ret_ch; rx_valid && rx_first |=> ch_in_smp[0] == $past(rx_data) || ch_in_smp[0] == ch_analog_smp[0];
   endproperty
   property p_post; (~ch_bus_post & ~ch_tap_led) == '0; endproperty
   property p_rst; $rose(rst_n) |-> ch_in_smp == ch_analog_smp && ch_tap_led == '0; endproperty
   property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   property p_ret_hold; !rx_valid |=> $stable(pb_ret_l) && $stable(pb_ret_r); endproperty
   a_pb: assert property (p_pb) else $error("playback return mismatch");
   a_hold: assert property (p_hold) else $error("send slot changed while stalled");
   a_first: assert property (p_first) else $error("first flag off slot one");
   a_ret_ch: assert property (p_ret_ch) else $error("channel one input wrong");
   a_post: assert property (p_post) else $error("processing withheld with tap off");
   a_rst: assert property (p_rst) else $error("selects not cleared");
   a_wait: assert property (p_wait) else $error("register answer late");
   a_ret_hold: assert property (p_ret_hold) else $error("return changed idle");
endmodule : alr_props

bind alr_router alr_props alr_props_i (.clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .ch_analog_smp(ch_analog_smp), .ch_in_smp(ch_in_smp),
   .ch_tap_led(ch_tap_led), .ch_bus_post(ch_bus_post), .pb_ret_l(pb_ret_l), .pb_ret_r(pb_ret_r),
   .mon_ret_l(mon_ret_l), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_first(tx_first),
   .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first));

// ==== verification/testbench.sv ====
// Self-checking bench for the audio link router
`timescale 1ns/1ps
module testbench;
   localparam int W = alr_pkg::SMP_W;
   logic                  clk, rst_n, avs_read, avs_write, avs_waitrequest, frame_stb;
   logic                  tx_valid, tx_ready, tx_first, rx_valid, rx_first;
   logic [3:0]            avs_address;
   logic [31:0]           avs_writedata, avs_readdata, rd, tap_v, pair_v;
   logic [15:0][W-1:0]    ana, pre, post, ch_in;
   logic [12:0][W-1:0]    sl, sr;
   logic [W-1:0]          tb_smp, pbl, pbr, mol, mor, tx_data, rx_data, exp_v;
   logic [15:0]           led, bpost, src_m;
   logic [6:0]            stall;
   logic [W-1:0]          exp_q[$];
   logic [W-1:0]          ret_m[18];
   int                    rslot, cyc, error_cnt, checked;

   alr_router alr_router_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .frame_stb(frame_stb), .ch_analog_smp(ana), .ch_pre_smp(pre),
      .ch_post_smp(post), .src_l_smp(sl), .src_r_smp(sr), .talkback_smp(tb_smp), .ch_in_smp(ch_in),
      .ch_tap_led(led), .ch_bus_post(bpost), .pb_ret_l(pbl), .pb_ret_r(pbr), .mon_ret_l(mol),
      .mon_ret_r(mor), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_first(tx_first),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first));
   alr_host alr_host_i (.clk(clk), .rst_n(rst_n), .stall_pct(stall), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_smp(input logic [W-1:0] got, input logic [W-1:0] exp);
      chk_reg({8'h00, got}, {8'h00, exp});
   endtask : chk_smp

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk iff !avs_waitrequest);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic frame(input logic [31:0] tap, input logic [31:0] pair, input logic dup);
      logic [3:0] c;
      for (int i = 0; i < 16; i++) begin
         ana[i] <= W'($urandom);
         pre[i] <= W'($urandom);
         post[i] <= W'($urandom);
      end
      for (int i = 0; i < 13; i++) begin
         sl[i] <= W'($urandom);
         sr[i] <= W'($urandom);
      end
      tb_smp <= W'($urandom);
      @(posedge clk);
      for (int i = 0; i < 16; i++) exp_q.push_back(tap[i] && !src_m[i] ? post[i] : pre[i]);
      for (int p = 0; p < 8; p++) begin
         c = pair[4*p+:4];
         exp_q.push_back(c == alr_pkg::ALR_SRC_TALKBACK ? tb_smp : c < alr_pkg::N_SRC ? sl[c] : '0);
         exp_q.push_back(c == alr_pkg::ALR_SRC_TALKBACK ? tb_smp : c < alr_pkg::N_SRC ? sr[c] : '0);
      end
      frame_stb <= 1'b1;
      @(posedge clk);
      frame_stb <= 1'b0;
      // Second strobe lands mid-push and must be dropped
      if (dup) begin
         repeat (3) @(posedge clk);
         frame_stb <= 1'b1;
         @(posedge clk);
         frame_stb <= 1'b0;
      end
      while (exp_q.size() != 0) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : frame

   task automatic final_report();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      if (rst_n && tx_valid && tx_ready) begin
         exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : ~tx_data;
         chk_smp(tx_data, exp_v);
      end
      if (rx_valid) begin
         rslot = rx_first ? 0 : rslot;
         ret_m[rslot] <= rx_data;
         rslot = (rslot == 17) ? 0 : rslot + 1;
      end
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      rst_n = 1'b0;
      {avs_read, avs_write, frame_stb, avs_address, avs_writedata} = '0;
      {ana, pre, post, sl, sr, tb_smp} = '0;
      stall = 7'h00;
      src_m = 16'h0000;
      ret_m = '{default: '0};
      void'($urandom(2));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) begin
         bus(1'b0, 4'(2 * a), 32'h0, rd);
         chk_reg(rd, 32'h0);
      end
      $display("test reset done");
      for (int f = 0; f < 2; f++) begin
         stall <= 7'(f * 60);
         tap_v = {16'h0000, 16'($urandom)};
         pair_v = f ? 32'hFEDCBA98 : 32'h76543210;
         bus(1'b1, alr_pkg::REG_CH_TAP, tap_v, rd);
         bus(1'b1, alr_pkg::REG_PAIR, pair_v, rd);
         bus(1'b0, alr_pkg::REG_PAIR, 32'h0, rd);
         chk_reg(rd, pair_v);
         chk_reg({16'h0000, led}, tap_v);
         frame(tap_v, pair_v, 1'b0);
      end
      $display("test send done");
      src_m = 16'($urandom);
      bus(1'b1, alr_pkg::REG_CH_SRC, {16'h0000, src_m}, rd);
      repeat (200) @(posedge clk);
      #1;
      for (int i = 0; i < 16; i++) chk_smp(ch_in[i], src_m[i] ? ret_m[i] : ana[i]);
      chk_reg({16'h0000, bpost}, {16'h0000, ~(tap_v[15:0] & src_m)});
      chk_smp(pbl, ret_m[16]);
      chk_smp(pbr, ret_m[17]);
      chk_smp(mol, ret_m[16]);
      chk_smp(mor, ret_m[17]);
      frame(tap_v, pair_v, 1'b1);
      bus(1'b0, alr_pkg::REG_STATUS, 32'h0, rd);
      chk_reg(rd, 32'h00030001);
      bus(1'b1, alr_pkg::REG_STATUS, 32'h00000001, rd);
      bus(1'b0, alr_pkg::REG_STATUS, 32'h0, rd);
      chk_reg(rd, 32'h00030000);
      $display("test return done");
      final_report();
   end
endmodule : testbench
